// ### rtl/tmx_test_mode.sv
module tmx_test_mode
#(
  parameter int CH_W = 48
)
(
  input  wire logic            clock_in,
  input  wire logic            nrst_in,
  input  wire logic            power_good_input_in,
  input  wire logic            rtc_well_reset_pin_in,
  input  wire logic [CH_W-1:0] chain_pins_in [tmx_pkg::CHAINS],
  output logic                 test_active_out,
  output logic                 float_all_out,
  output logic [3:0]           chain_enable_out,
  output logic                 audio_link_serial_in_one_out,
  output logic                 audio_link_serial_in_one_oe_out,
  output logic                 battery_low_input_out,
  output logic                 battery_low_input_oe_out,
  output logic                 ring_indicate_input_out,
  output logic                 ring_indicate_input_oe_out,
  output logic                 overcurrent_zero_input_out,
  output logic                 overcurrent_zero_input_oe_out
);
  // pins listed are simply not ports of the chain inputs
  generate
    if (CH_W < 1)
    begin : g_bad_width
      $error("chain width must be at least one");
    end
  endgenerate

  tmx_sel_if sel ();

  tmx_low_counter u_cnt (
    .clock_in              (clock_in),
    .nrst_in               (nrst_in),
    .power_good_input_in   (power_good_input_in),
    .rtc_well_reset_pin_in (rtc_well_reset_pin_in),
    .sel                   (sel)
  );

  function automatic tmx_pkg::tmx_mode_t tmx_decode(input logic [5:0] c);
    tmx_pkg::tmx_mode_t m;
    m = tmx_pkg::TMX_NORMAL;
    if (c == 6'(tmx_pkg::CHAIN_FIRST))
      m = tmx_pkg::TMX_CHAIN1;
    else if (c == 6'(tmx_pkg::CHAIN_FIRST + 1))
      m = tmx_pkg::TMX_CHAIN2;
    else if (c == 6'(tmx_pkg::CHAIN_FIRST + 2))
      m = tmx_pkg::TMX_CHAIN3;
    else if (c == 6'(tmx_pkg::CHAIN_LAST))
      m = tmx_pkg::TMX_CHAIN4;
    else if (c >= 6'(tmx_pkg::FLOAT_CNT) && c <= 6'(tmx_pkg::RSV_LAST))
      m = tmx_pkg::TMX_FLOAT; // reserved counts treated as float, safe choice
    return m;
  endfunction

  tmx_pkg::tmx_mode_t mode;
  tmx_pkg::tmx_mode_t next_mode;
  logic [3:0]         parity;
  logic [3:0]         chain_on;
  logic [3:0]         next_chain_on;
  logic [3:0]         next_res;
  logic [3:0]         res;
  logic               next_active;
  logic               next_float;

  // cascade from first input to last; inverted so all-zero gives one
  genvar g;
  generate
    for (g = 0; g < tmx_pkg::CHAINS; g++)
    begin : g_chain
      logic [CH_W-1:0] casc;
      assign casc[0] = chain_pins_in[g][0];
      for (genvar k = 1; k < CH_W; k++)
      begin : g_stage
        assign casc[k] = casc[k-1] ^ chain_pins_in[g][k];
      end
      assign parity[g] = ~casc[CH_W-1];
    end
  endgenerate

  always_comb
  begin
    next_mode = mode;
    if (!power_good_input_in)
    begin
      next_mode = tmx_pkg::TMX_NORMAL;
    end
    else if (sel.count_done)
    begin
      next_mode = tmx_decode(sel.count_value);
    end
    next_chain_on = 4'h0;
    case (next_mode)
      tmx_pkg::TMX_CHAIN1: next_chain_on = 4'h1;
      tmx_pkg::TMX_CHAIN2: next_chain_on = 4'h2;
      tmx_pkg::TMX_CHAIN3: next_chain_on = 4'h4;
      tmx_pkg::TMX_CHAIN4: next_chain_on = 4'h8;
      default:             next_chain_on = 4'h0;
    endcase
    next_float  = next_mode == tmx_pkg::TMX_FLOAT;
    next_active = next_mode != tmx_pkg::TMX_NORMAL;
    next_res    = parity;
  end

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      mode             <= tmx_pkg::TMX_NORMAL;
      chain_on         <= 4'h0;
      res              <= 4'hF;
      test_active_out  <= 1'b0;
      float_all_out    <= 1'b0;
    end
    else
    begin
      mode             <= next_mode;
      chain_on         <= next_chain_on;
      res              <= next_res;
      test_active_out  <= next_active;
      float_all_out    <= next_float;
    end
  end

  // result pins drive only for their own chain
  assign chain_enable_out                = chain_on;
  assign audio_link_serial_in_one_out    = res[0];
  assign audio_link_serial_in_one_oe_out = chain_on[0];
  assign battery_low_input_out           = res[1];
  assign battery_low_input_oe_out        = chain_on[1];
  assign ring_indicate_input_out         = res[2];
  assign ring_indicate_input_oe_out      = chain_on[2];
  assign overcurrent_zero_input_out      = res[3];
  assign overcurrent_zero_input_oe_out   = chain_on[3];

  property p_float_no_drive;
    @(posedge clock_in) disable iff (!nrst_in)
    float_all_out |-> chain_enable_out == 4'h0;
  endproperty
  a_float_no_drive: assert property (p_float_no_drive) else $error("drive in float mode");

  property p_one_hot;
    @(posedge clock_in) disable iff (!nrst_in)
    $onehot0(chain_enable_out);
  endproperty
  a_one_hot: assert property (p_one_hot) else $error("more than one chain on");

  property p_pg_drop;
    @(posedge clock_in) disable iff (!nrst_in)
    !power_good_input_in |=> !test_active_out;
  endproperty
  a_pg_drop: assert property (p_pg_drop) else $error("mode kept without power good");

  property p_hold;
    @(posedge clock_in) disable iff (!nrst_in)
    (power_good_input_in && !sel.count_done) |=> $stable(chain_enable_out);
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed without selection");

  property p_four;
    @(posedge clock_in) disable iff (!nrst_in)
    (power_good_input_in && sel.count_done && sel.count_value == 6'(tmx_pkg::CHAIN_FIRST))
      |=> chain_enable_out == 4'h1;
  endproperty
  a_four: assert property (p_four) else $error("count four not chain one");

  property p_eight;
    @(posedge clock_in) disable iff (!nrst_in)
    (power_good_input_in && sel.count_done && sel.count_value == 6'(tmx_pkg::FLOAT_CNT))
      |=> float_all_out;
  endproperty
  a_eight: assert property (p_eight) else $error("count eight not float");

  property p_short;
    @(posedge clock_in) disable iff (!nrst_in)
    (power_good_input_in && sel.count_done &&
     (sel.count_value < 6'(tmx_pkg::CHAIN_FIRST) || sel.count_value > 6'(tmx_pkg::RSV_LAST)))
      |=> !test_active_out;
  endproperty
  a_short: assert property (p_short) else $error("out of range count not normal");

  property p_parity;
    @(posedge clock_in) disable iff (!nrst_in)
    1'b1 |=> res[0] == ~^$past(chain_pins_in[0]);
  endproperty
  a_parity: assert property (p_parity) else $error("chain one parity wrong");
endmodule // tmx_test_mode

// ### common/tmx_pkg.sv
package tmx_pkg;
  localparam int CNT_W       = 6;
  localparam int CHAIN_FIRST = 4;
  localparam int CHAIN_LAST  = 7;
  localparam int FLOAT_CNT   = 8;
  localparam int RSV_LAST    = 42;
  localparam int CLK_NS      = 50;
  localparam int CHAINS      = 4;
  localparam logic [CNT_W-1:0] CNT_SAT = 6'h2B;

  typedef enum logic [2:0] {
    TMX_NORMAL,
    TMX_CHAIN1,
    TMX_CHAIN2,
    TMX_CHAIN3,
    TMX_CHAIN4,
    TMX_FLOAT
  } tmx_mode_t;
endpackage

// ### common/tmx_sel_if.sv
interface tmx_sel_if;
  logic                  count_done;
  logic [5:0]            count_value;
  modport counter (output count_done, output count_value);
  modport decoder (input count_done, input count_value);
endinterface

// ### rtl/tmx_low_counter.sv
module tmx_low_counter
(
  input  wire logic clock_in,
  input  wire logic nrst_in,
  input  wire logic power_good_input_in,
  input  wire logic rtc_well_reset_pin_in,
  tmx_sel_if.counter sel
);
  logic                         low_d;
  logic                         next_low_d;
  logic [tmx_pkg::CNT_W-1:0]    cnt;
  logic [tmx_pkg::CNT_W-1:0]    next_cnt;
  logic                         done;
  logic                         next_done;

  always_comb
  begin
    next_low_d = rtc_well_reset_pin_in == 1'b0;
    next_cnt   = cnt;
    next_done  = 1'b0;
    if (!power_good_input_in)
    begin
      next_cnt = '0;
    end
    else if (!rtc_well_reset_pin_in)
    begin
      if (!low_d)
      begin
        next_cnt = 6'h01; // restart on falling edge
      end
      else if (cnt != tmx_pkg::CNT_SAT)
      begin
        next_cnt = cnt + 6'h01; // saturates above the reserved range
      end
    end
    else if (low_d)
    begin
      next_done = 1'b1; // rising edge closes the count
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      low_d <= 1'b0;
      cnt   <= '0;
      done  <= 1'b0;
    end
    else
    begin
      low_d <= next_low_d;
      cnt   <= next_cnt;
      done  <= next_done;
    end
  end

  assign sel.count_done  = done;
  assign sel.count_value = cnt;
endmodule // tmx_low_counter

// ### verif/tmx_tester.sv
module tmx_tester
#(
  parameter int W = 8
)
(
  input  wire logic         clock_in,
  output logic              pin_out,
  output logic [W-1:0]      pins_out [tmx_pkg::CHAINS]
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    pin_out = 1'b1;
    foreach (pins_out[i]) pins_out[i] = '0;
  end

  // low pulse of n clocks, then settle time for the mode to land
  task automatic select(input int n);
    @(negedge clock_in) pin_out = 1'b0;
    repeat (n) @(negedge clock_in);
    pin_out = 1'b1;
    repeat (3) @(negedge clock_in);
  endtask

  task automatic drive(input int c, input logic [W-1:0] v);
    @(negedge clock_in) pins_out[c] = v;
    @(negedge clock_in);
  endtask
endmodule // tmx_tester

// ### verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = 8;

  logic         clk = 1'b0;
  logic         nrst;
  logic         pgood;
  logic         rtc;
  logic [W-1:0] pins [tmx_pkg::CHAINS];
  logic         act;
  logic         flt;
  logic [3:0]   ce;
  wire  [3:0]   oe;
  wire  [3:0]   res;
  int           error_cnt = 0;
  int           n_compared = 0;

  always #25 clk = ~clk;

  tmx_tester #(.W(W)) tester (.clock_in(clk), .pin_out(rtc), .pins_out(pins));

  tmx_test_mode #(.CH_W(W)) dut
  (
    .clock_in(clk), .nrst_in(nrst), .power_good_input_in(pgood), .rtc_well_reset_pin_in(rtc),
    .chain_pins_in(pins), .test_active_out(act), .float_all_out(flt), .chain_enable_out(ce),
    .audio_link_serial_in_one_out(res[0]), .audio_link_serial_in_one_oe_out(oe[0]),
    .battery_low_input_out(res[1]), .battery_low_input_oe_out(oe[1]),
    .ring_indicate_input_out(res[2]), .ring_indicate_input_oe_out(oe[2]),
    .overcurrent_zero_input_out(res[3]), .overcurrent_zero_input_oe_out(oe[3])
  );

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic t_modes();
    int         cnts [10] = '{4, 5, 6, 7, 8, 3, 4, 43, 7, 50};
    logic [3:0] ece;
    foreach (cnts[i])
    begin
      tester.select(cnts[i]);
      ece = 4'h0;
      if (cnts[i] >= 4 && cnts[i] <= 7)
        ece[cnts[i] - 4] = 1'b1;
      chk("chain_enable", {4'h0, ece}, {4'h0, ce});
      chk("result_oe", {4'h0, ece}, {4'h0, oe});
      chk("float_all", {7'h00, cnts[i] == 8}, {7'h00, flt});
      chk("test_active", {7'h00, cnts[i] >= 4 && cnts[i] <= 8}, {7'h00, act});
    end
    $display("mode selection test done");
  endtask

  task automatic t_parity();
    logic [W-1:0] v;
    for (int c = 0; c < 4; c++)
    begin
      tester.select(4 + c);
      for (int k = 0; k <= W; k++)
      begin
        v = W'((1 << k) - 1);
        tester.drive(c, v);
        chk("chain_result", {7'h00, (k % 2) == 0}, {7'h00, res[c]});
      end
      tester.drive(c, '0);
    end
    $display("parity chain test done");
  endtask

  task automatic t_pgood();
    tester.select(6);
    chk("enable_before_power_drop", 8'h04, {4'h0, ce});
    @(negedge clk) pgood = 1'b0;
    repeat (2) @(negedge clk);
    chk("active_after_power_drop", 8'h00, {7'h00, act});
    chk("enable_after_power_drop", 8'h00, {4'h0, ce});
    tester.select(5);
    chk("active_without_power_good", 8'h00, {7'h00, act});
    @(negedge clk) pgood = 1'b1;
    tester.select(5);
    chk("enable_after_power_return", 8'h02, {4'h0, ce});
    $display("power good test done");
  endtask

  initial
  begin
    nrst = 1'b0;
    pgood = 1'b1;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    t_modes();
    t_parity();
    t_pgood();
    conclude();
  end

  initial
  begin
    #(50 * 20000);
    error_cnt++;
    conclude();
  end
endmodule // tb_top
